// ===== rtl/pnoc_pkg.sv
// constants, register map and carrier types for the phase/neutral overcurrent
// decision block; assumes a 100 MHz system clock and phasor inputs in fixed point
package pnoc_pkg;
	// time base
	localparam int CLK_PERIOD_NS    = 10;
	localparam int PASS_TIME_NS     = 1000000;
	localparam int PASS_CYC         = PASS_TIME_NS / CLK_PERIOD_NS;
	localparam int MEM_TIME_MS      = 1000;
	localparam int MEM_TICKS        = MEM_TIME_MS * 1000000 / PASS_TIME_NS;
	localparam int DT_STEP_MS       = 10;
	localparam int DT_STEP_TICKS    = DT_STEP_MS * 1000000 / PASS_TIME_NS;
	localparam int DIR_SETTLE_MS    = 8;
	localparam int DIR_SETTLE_CYC   = DIR_SETTLE_MS * 1000000 / CLK_PERIOD_NS;
	localparam int CNT_W            = 20;
	localparam int MEM_W            = 12;

	// angles: 16-bit binary fraction of a full turn
	localparam logic [15:0] ANG_90   = 16'h4000;
	localparam logic [15:0] ANG_M90  = 16'hC000;
	localparam logic [15:0] ANG_180  = 16'h8000;
	// magnitudes: 1 pu = 10000 counts
	localparam logic [6:0]  PCT_FULL    = 7'h64;
	localparam logic [6:0]  CT_MIN_PCT  = 7'h05;
	localparam int          RESTRAINT_SH = 4;

	// register byte addresses
	localparam logic [7:0] REG_CTRL      = 8'h00;
	localparam logic [7:0] REG_CHAR_ANG  = 8'h04;
	localparam logic [7:0] REG_POL_THR   = 8'h08;
	localparam logic [7:0] REG_CT_NOM    = 8'h0C;
	localparam logic [7:0] REG_PIOC_PKP  = 8'h10;
	localparam logic [7:0] REG_PIOC_DLY  = 8'h14;
	localparam logic [7:0] REG_NTOC_PKP  = 8'h18;
	localparam logic [7:0] REG_NTOC_TDM  = 8'h1C;
	localparam logic [7:0] REG_NIOC_PKP  = 8'h20;
	localparam logic [7:0] REG_NIOC_DLY  = 8'h24;
	localparam logic [7:0] REG_STATUS    = 8'h28;

	// control field positions
	localparam int CTL_DIR_EN    = 0;
	localparam int CTL_ROT_ACB   = 1;
	localparam int CTL_SRC_SEL   = 2;
	localparam int CTL_BLK_EXP   = 3;
	localparam int CTL_NTOC_RMS  = 4;
	localparam int CTL_NRST_INST = 5;
	localparam int CTL_PIOC_SUP  = 6;
	localparam int CTL_PIOC_EN   = 7;
	localparam int CTL_NTOC_EN   = 8;
	localparam int CTL_NIOC_EN   = 9;
	localparam int CTL_W         = 10;

	// reset values
	localparam logic [9:0]  CTRL_RST    = 10'h000;
	localparam logic [15:0] ECA_RST     = 16'h0000;
	localparam logic [15:0] POL_THR_RST = 16'h01F4;
	localparam logic [15:0] CT_NOM_RST  = 16'h2710;
	localparam logic [15:0] PKP_RST     = 16'h2710;
	localparam logic [15:0] DLY_RST     = 16'h0000;

	// one measured source; line voltage index 0=AB, 1=BC, 2=CA
	typedef struct packed {
		logic [2:0][15:0] i_mag;
		logic [2:0][15:0] i_ang;
		logic [2:0][15:0] v_mag;
		logic [2:0][15:0] v_ang;
		logic [15:0]      i0_mag;
		logic [15:0]      i1_mag;
		logic [15:0]      i3n_rms;
	} pnoc_src_s;

	typedef struct packed {
		logic [2:0] mem_exp;
		logic       nioc_op;
		logic       nioc_pkp;
		logic       ntoc_op;
		logic       ntoc_pkp;
		logic [2:0] pioc_op;
		logic [2:0] pioc_pkp;
		logic [2:0] dir;
	} pnoc_out_s;
endpackage

// ===== rtl/pnoc_top.sv
// phase directional supervision, phase and neutral instantaneous overcurrent,
// neutral definite-time overcurrent; assumes phasors from same-clock logic and
// a register master on the plain strobe port
//
// The address-and-strobe port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// definite-time stage shared by the instantaneous elements
module pnoc_dt_timer (
	input  wire logic        mclk,
	input  wire logic        reset,
	input  wire logic        tick,
	input  wire logic        active,
	input  wire logic [15:0] delay_steps,
	output logic             pickup,
	output logic             operate
);
	logic [pnoc_pkg::CNT_W-1:0] target;
	logic [pnoc_pkg::CNT_W-1:0] cnt_ff;

	assign target = pnoc_pkg::CNT_W'(delay_steps * pnoc_pkg::DT_STEP_TICKS); // R21

	always_ff @(posedge mclk) begin
		if (reset) begin
			cnt_ff  <= '0;
			pickup  <= 1'b0;
			operate <= 1'b0;
		end else if (tick) begin // R22
			pickup <= active;
			if (!active) begin
				cnt_ff  <= '0;
				operate <= 1'b0;
			end else begin
				operate <= (cnt_ff >= target); // R21
				if (cnt_ff < target)
					cnt_ff <= cnt_ff + 1'b1;
			end
		end
	end

	AST_DT_OPERATE: assert property (@(posedge mclk) disable iff (reset) // R21
		tick && active && (cnt_ff >= target) |=> operate && pickup)
		else $error("definite time stage missed its operate");
	AST_DT_NO_EARLY: assert property (@(posedge mclk) disable iff (reset) // R1
		tick && (cnt_ff < target) |=> !operate)
		else $error("definite time stage operated early");
endmodule

////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// R1: phase instantaneous element, optional definite delay
// R2: one directional element per phase, drives blocks
// R3: polarizing from rotated line voltage per sequence
// R4: quadrature voltage shifted leading by characteristic angle
// R5: output zero when disabled or current low
// R6: zero within plus minus ninety, else one
// R7: remembered voltage angle valid one second
// R8: after expiry block or permit per setting
// R9: normal blocking resumes when voltage returns
// R10: settable polarizing threshold, default 0.05 pu
// R11: source select feeds current and voltage
// R12: logic one on block input inhibits element
// R13: blocking established within about eight milliseconds
// R14: user adds ten to twenty ms delay
// R15: neutral time input is 3I0, phasor or rms
// R16: neutral time reset timed or instantaneous
// R17: block resets accumulator per reset mode
// R18: neutral pickup held until memory fully reset
// R19: neutral instantaneous on derived neutral phasor
// R20: neutral operating quantity uses 1/16 restraint
// R21: definite delay in 10 ms steps to 600 s
// R22: everything evaluated once per protection pass
module pnoc_top #(
	parameter int PASS_CYCLES = pnoc_pkg::PASS_CYC
) (
	input  wire logic              mclk,
	input  wire logic              reset,
	input  wire logic [7:0]        reg_addr,
	input  wire logic [31:0]       reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic [31:0]            reg_rdata,
	input  wire pnoc_pkg::pnoc_src_s meas_src0,
	input  wire pnoc_pkg::pnoc_src_s meas_src1,
	input  wire logic              phase_ioc_block,
	input  wire logic              neutral_toc_block,
	input  wire logic              neutral_ioc_block,
	output pnoc_pkg::pnoc_out_s    prot_out,
	output logic                   pass_tick
);
	////////////////////////////////////////////////////////////////////////////
	// settings registers
	logic [pnoc_pkg::CTL_W-1:0] ctrl_ff;
	logic [15:0]                char_ang_ff;
	logic [15:0]                pol_thr_ff;
	logic [15:0]                ct_nom_ff;
	logic [15:0]                pioc_pkp_ff;
	logic [15:0]                pioc_dly_ff;
	logic [15:0]                ntoc_pkp_ff;
	logic [15:0]                ntoc_tdm_ff;
	logic [15:0]                nioc_pkp_ff;
	logic [15:0]                nioc_dly_ff;
	logic [31:0]                nxt_rdata;

	always_ff @(posedge mclk) begin
		if (reset) begin
			ctrl_ff     <= pnoc_pkg::CTRL_RST;
			char_ang_ff <= pnoc_pkg::ECA_RST;
			pol_thr_ff  <= pnoc_pkg::POL_THR_RST; // R10
			ct_nom_ff   <= pnoc_pkg::CT_NOM_RST;
			pioc_pkp_ff <= pnoc_pkg::PKP_RST;
			pioc_dly_ff <= pnoc_pkg::DLY_RST;
			ntoc_pkp_ff <= pnoc_pkg::PKP_RST;
			ntoc_tdm_ff <= pnoc_pkg::DLY_RST;
			nioc_pkp_ff <= pnoc_pkg::PKP_RST;
			nioc_dly_ff <= pnoc_pkg::DLY_RST;
		end else if (reg_wr) begin
			case (reg_addr)
				pnoc_pkg::REG_CTRL:     ctrl_ff     <= reg_wdata[pnoc_pkg::CTL_W-1:0];
				pnoc_pkg::REG_CHAR_ANG: char_ang_ff <= reg_wdata[15:0];
				pnoc_pkg::REG_POL_THR:  pol_thr_ff  <= reg_wdata[15:0]; // R10
				pnoc_pkg::REG_CT_NOM:   ct_nom_ff   <= reg_wdata[15:0];
				pnoc_pkg::REG_PIOC_PKP: pioc_pkp_ff <= reg_wdata[15:0];
				pnoc_pkg::REG_PIOC_DLY: pioc_dly_ff <= reg_wdata[15:0];
				pnoc_pkg::REG_NTOC_PKP: ntoc_pkp_ff <= reg_wdata[15:0];
				pnoc_pkg::REG_NTOC_TDM: ntoc_tdm_ff <= reg_wdata[15:0];
				pnoc_pkg::REG_NIOC_PKP: nioc_pkp_ff <= reg_wdata[15:0];
				pnoc_pkg::REG_NIOC_DLY: nioc_dly_ff <= reg_wdata[15:0];
				default: ;
			endcase
		end
	end

	always_comb begin
		nxt_rdata = 32'h0000_0000;
		case (reg_addr)
			pnoc_pkg::REG_CTRL:     nxt_rdata = {22'h00_0000, ctrl_ff};
			pnoc_pkg::REG_CHAR_ANG: nxt_rdata = {16'h0000, char_ang_ff};
			pnoc_pkg::REG_POL_THR:  nxt_rdata = {16'h0000, pol_thr_ff};
			pnoc_pkg::REG_CT_NOM:   nxt_rdata = {16'h0000, ct_nom_ff};
			pnoc_pkg::REG_PIOC_PKP: nxt_rdata = {16'h0000, pioc_pkp_ff};
			pnoc_pkg::REG_PIOC_DLY: nxt_rdata = {16'h0000, pioc_dly_ff};
			pnoc_pkg::REG_NTOC_PKP: nxt_rdata = {16'h0000, ntoc_pkp_ff};
			pnoc_pkg::REG_NTOC_TDM: nxt_rdata = {16'h0000, ntoc_tdm_ff};
			pnoc_pkg::REG_NIOC_PKP: nxt_rdata = {16'h0000, nioc_pkp_ff};
			pnoc_pkg::REG_NIOC_DLY: nxt_rdata = {16'h0000, nioc_dly_ff};
			pnoc_pkg::REG_STATUS:   nxt_rdata = {16'h0000, prot_out};
			default:                nxt_rdata = 32'h0000_0000;
		endcase
	end

	// read data stand for one cycle only, zero otherwise
	always_ff @(posedge mclk) begin
		if (reset)
			reg_rdata <= 32'h0000_0000;
		else
			reg_rdata <= reg_rd ? nxt_rdata : 32'h0000_0000;
	end

	////////////////////////////////////////////////////////////////////////////
	// protection pass divider
	logic [31:0] pass_cnt_ff;

	always_ff @(posedge mclk) begin
		if (reset) begin
			pass_cnt_ff <= 32'h0000_0000;
			pass_tick   <= 1'b0;
		end else if (pass_cnt_ff >= 32'(PASS_CYCLES - 1)) begin // R22
			pass_cnt_ff <= 32'h0000_0000;
			pass_tick   <= 1'b1;
		end else begin
			pass_cnt_ff <= pass_cnt_ff + 32'h0000_0001;
			pass_tick   <= 1'b0;
		end
	end

	// a reverse fault is seen within one pass, well inside the settling time
	AST_PASS_SPACING: assert property (@(posedge mclk) disable iff (reset) // R13
		pass_cnt_ff < 32'(pnoc_pkg::DIR_SETTLE_CYC))
		else $error("protection pass slower than directional settling time");

	////////////////////////////////////////////////////////////////////////////
	// source selection
	pnoc_pkg::pnoc_src_s src;

	assign src = ctrl_ff[pnoc_pkg::CTL_SRC_SEL] ? meas_src1 : meas_src0; // R11

	AST_SRC_SELECT: assert property (@(posedge mclk) disable iff (reset) // R11
		ctrl_ff[pnoc_pkg::CTL_SRC_SEL] |-> (src.i_ang == meas_src1.i_ang)
			&& (src.v_mag == meas_src1.v_mag))
		else $error("directional source select not followed");

	////////////////////////////////////////////////////////////////////////////
	// per-phase directional element and phase instantaneous element
	logic [22:0] ct_min;

	assign ct_min = 23'(ct_nom_ff) * 23'(pnoc_pkg::CT_MIN_PCT);

	for (genvar g = 0; g < 3; g++) begin : g_phase
		localparam int LINE = (g + 1) % 3; // R3
		logic [15:0]               line_ang;
		logic [15:0]               pol_ang;
		logic [15:0]               ang_diff;
		logic [22:0]               i_pct;
		logic                      cur_ok;
		logic                      v_ok;
		logic                      in_zone;
		logic                      mem_live;
		logic                      nxt_dir;
		logic [15:0]               mem_ang_ff;
		logic [pnoc_pkg::MEM_W-1:0] mem_cnt_ff;
		logic                      mem_armed_ff;
		logic                      dir_ff;
		logic                      mem_exp_ff;
		logic                      pioc_active;

		// reverse rotation uses the opposite line voltage, i.e. plus 180
		assign line_ang = src.v_ang[LINE]
			+ (ctrl_ff[pnoc_pkg::CTL_ROT_ACB] ? pnoc_pkg::ANG_180 : 16'h0000); // R3
		assign v_ok     = src.v_mag[LINE] > pol_thr_ff; // R10
		assign mem_live = !v_ok && mem_armed_ff
			&& (mem_cnt_ff < pnoc_pkg::MEM_W'(pnoc_pkg::MEM_TICKS)); // R7
		assign pol_ang  = (v_ok ? line_ang : mem_ang_ff) + char_ang_ff; // R4
		assign ang_diff = src.i_ang[g] - pol_ang;
		assign in_zone  = (ang_diff <= pnoc_pkg::ANG_90)
			|| (ang_diff >= pnoc_pkg::ANG_M90); // R6
		assign i_pct    = 23'(src.i_mag[g]) * 23'(pnoc_pkg::PCT_FULL);
		assign cur_ok   = i_pct >= ct_min; // R5

		always_comb begin
			if (!ctrl_ff[pnoc_pkg::CTL_DIR_EN] || !cur_ok)
				nxt_dir = 1'b0; // R5
			else if (v_ok || mem_live)
				nxt_dir = !in_zone; // R6 R9
			else
				nxt_dir = ctrl_ff[pnoc_pkg::CTL_BLK_EXP]; // R8
		end

		// memory holds the angle last seen above threshold
		always_ff @(posedge mclk) begin
			if (reset) begin
				mem_ang_ff   <= 16'h0000;
				mem_cnt_ff   <= '0;
				mem_armed_ff <= 1'b0;
				mem_exp_ff   <= 1'b0;
			end else if (pass_tick) begin // R22
				mem_exp_ff <= !v_ok && !mem_live; // R8
				if (v_ok) begin
					mem_ang_ff   <= line_ang; // R7
					mem_cnt_ff   <= '0;
					mem_armed_ff <= 1'b1;
				end else if (mem_live) begin
					mem_cnt_ff <= mem_cnt_ff + 1'b1;
				end
			end
		end

		always_ff @(posedge mclk) begin
			if (reset)
				dir_ff <= 1'b0;
			else if (pass_tick)
				dir_ff <= nxt_dir; // R2 R13
		end

		assign prot_out.dir[g]     = dir_ff;
		// held per pass, so status agrees with the other flags
		assign prot_out.mem_exp[g] = mem_exp_ff;

		// supervision: a one from the directional element is a block
		assign pioc_active = ctrl_ff[pnoc_pkg::CTL_PIOC_EN]
			&& (src.i_mag[g] > pioc_pkp_ff) // R1
			&& !phase_ioc_block // R12
			&& !(ctrl_ff[pnoc_pkg::CTL_PIOC_SUP] && dir_ff); // R2 R12

		pnoc_dt_timer u_pioc (
			.mclk        (mclk),
			.reset       (reset),
			.tick        (pass_tick),
			.active      (pioc_active),
			.delay_steps (pioc_dly_ff),
			.pickup      (prot_out.pioc_pkp[g]),
			.operate     (prot_out.pioc_op[g])
		);

		AST_DIR_OFF: assert property (@(posedge mclk) disable iff (reset) // R5
			pass_tick && (!ctrl_ff[pnoc_pkg::CTL_DIR_EN] || !cur_ok) |=> !dir_ff)
			else $error("directional output not forced low");
		AST_DIR_ZONE: assert property (@(posedge mclk) disable iff (reset) // R6
			pass_tick && ctrl_ff[pnoc_pkg::CTL_DIR_EN] && cur_ok && v_ok
			|=> dir_ff == !$past(in_zone))
			else $error("directional decision wrong for angle");
		AST_MEM_USE: assert property (@(posedge mclk) disable iff (reset) // R7
			pass_tick && ctrl_ff[pnoc_pkg::CTL_DIR_EN] && cur_ok && mem_live
			|=> dir_ff == !$past(in_zone) && $stable(mem_ang_ff))
			else $error("voltage memory not used after collapse");
		AST_MEM_EXPIRY: assert property (@(posedge mclk) disable iff (reset) // R8
			pass_tick && ctrl_ff[pnoc_pkg::CTL_DIR_EN] && cur_ok && !v_ok && !mem_live
			|=> dir_ff == $past(ctrl_ff[pnoc_pkg::CTL_BLK_EXP]))
			else $error("expiry action does not follow setting");
		AST_PIOC_BLOCKED: assert property (@(posedge mclk) disable iff (reset) // R12
			pass_tick && ctrl_ff[pnoc_pkg::CTL_PIOC_SUP] && dir_ff
			|=> !prot_out.pioc_pkp[g])
			else $error("blocked phase element picked up");
	end

	////////////////////////////////////////////////////////////////////////////
	// neutral time overcurrent, definite time curve
	logic [17:0]                 i0_x3;
	logic [17:0]                 ntoc_qty;
	logic                        ntoc_above;
	logic                        ntoc_blk;
	logic                        ntoc_inst;
	logic [pnoc_pkg::CNT_W-1:0]  ntoc_target;
	logic [pnoc_pkg::CNT_W-1:0]  ntoc_acc_ff;
	logic [pnoc_pkg::CNT_W-1:0]  nxt_ntoc_acc;
	logic                        ntoc_pkp_out_ff;
	logic                        ntoc_op_out_ff;

	assign i0_x3       = 18'(src.i0_mag) * 18'h0_0003;
	assign ntoc_qty    = ctrl_ff[pnoc_pkg::CTL_NTOC_RMS] ? 18'(src.i3n_rms) : i0_x3; // R15
	assign ntoc_above  = ntoc_qty > 18'(ntoc_pkp_ff);
	assign ntoc_blk    = neutral_toc_block || !ctrl_ff[pnoc_pkg::CTL_NTOC_EN]; // R12
	assign ntoc_inst   = ctrl_ff[pnoc_pkg::CTL_NRST_INST]; // R16
	assign ntoc_target = pnoc_pkg::CNT_W'(ntoc_tdm_ff * pnoc_pkg::DT_STEP_TICKS); // R21

	always_comb begin
		nxt_ntoc_acc = ntoc_acc_ff;
		if (ntoc_blk || !ntoc_above) begin
			if (ntoc_inst)
				nxt_ntoc_acc = '0; // R17
			else if (ntoc_acc_ff != '0)
				nxt_ntoc_acc = ntoc_acc_ff - 1'b1; // R16
		end else if (ntoc_acc_ff < ntoc_target) begin
			nxt_ntoc_acc = ntoc_acc_ff + 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			ntoc_acc_ff     <= '0;
			ntoc_pkp_out_ff <= 1'b0;
			ntoc_op_out_ff  <= 1'b0;
		end else if (pass_tick) begin // R22
			ntoc_acc_ff     <= nxt_ntoc_acc;
			// timed reset keeps pickup until the memory drains
			ntoc_pkp_out_ff <= (ntoc_above && !ntoc_blk)
				|| (!ntoc_inst && nxt_ntoc_acc != '0); // R18
			ntoc_op_out_ff  <= ntoc_above && !ntoc_blk && (ntoc_acc_ff >= ntoc_target);
		end
	end

	assign prot_out.ntoc_pkp = ntoc_pkp_out_ff;
	assign prot_out.ntoc_op  = ntoc_op_out_ff;

	AST_NTOC_INST_CLEAR: assert property (@(posedge mclk) disable iff (reset) // R17
		pass_tick && ntoc_inst && (ntoc_blk || !ntoc_above)
		|=> ntoc_acc_ff == '0 && !ntoc_pkp_out_ff)
		else $error("instantaneous reset did not clear accumulator");
	AST_NTOC_PKP_HOLD: assert property (@(posedge mclk) disable iff (reset) // R18
		pass_tick && !ntoc_inst && (nxt_ntoc_acc != '0) |=> ntoc_pkp_out_ff)
		else $error("neutral pickup dropped before memory reset");
	AST_NTOC_TIMED_DRAIN: assert property (@(posedge mclk) disable iff (reset) // R16
		pass_tick && !ntoc_inst && !ntoc_above && (ntoc_acc_ff != '0)
		|=> ntoc_acc_ff == $past(ntoc_acc_ff) - 1'b1)
		else $error("timed reset did not drain by one pass");

	////////////////////////////////////////////////////////////////////////////
	// neutral instantaneous overcurrent with positive-sequence restraint
	logic [15:0] i1_part;
	logic [15:0] nioc_net;
	logic [17:0] nioc_qty;
	logic        nioc_active;

	assign i1_part  = src.i1_mag >> pnoc_pkg::RESTRAINT_SH; // R20
	// restraint larger than zero sequence gives no operating quantity
	assign nioc_net = (src.i0_mag > i1_part) ? (src.i0_mag - i1_part) : 16'h0000;
	assign nioc_qty = 18'(nioc_net) * 18'h0_0003; // R19 R20
	assign nioc_active = ctrl_ff[pnoc_pkg::CTL_NIOC_EN] && !neutral_ioc_block // R12
		&& (nioc_qty > 18'(nioc_pkp_ff)); // R19

	pnoc_dt_timer u_nioc (
		.mclk        (mclk),
		.reset       (reset),
		.tick        (pass_tick),
		.active      (nioc_active),
		.delay_steps (nioc_dly_ff),
		.pickup      (prot_out.nioc_pkp),
		.operate     (prot_out.nioc_op)
	);

	AST_NIOC_QTY: assert property (@(posedge mclk) disable iff (reset) // R20
		(src.i0_mag >= (src.i1_mag >> pnoc_pkg::RESTRAINT_SH))
		|-> nioc_qty == 18'(src.i0_mag - (src.i1_mag >> pnoc_pkg::RESTRAINT_SH)) * 18'h0_0003)
		else $error("neutral operating quantity wrong");
endmodule

`default_nettype wire

// ===== sim/pnoc_meas_model.sv
// measurement side model: two phasor sources built from scalar setpoints
// assumes setpoints change just after rising edges of mclk
`timescale 1ns/1ps
`default_nettype none
module pnoc_meas_model (
	input  wire logic             mclk,
	input  wire logic [15:0]      im,
	input  wire logic [15:0]      ia,
	input  wire logic [15:0]      vm,
	input  wire logic [15:0]      va,
	input  wire logic [15:0]      i0,
	input  wire logic [15:0]      i1,
	input  wire logic [15:0]      rms,
	output var pnoc_pkg::pnoc_src_s src0,
	output var pnoc_pkg::pnoc_src_s src1
);
	// one angle for all phases, so every phase must give the same answer
	always_ff @(posedge mclk) begin
		src0 <= {{3{im}}, {3{ia}}, {3{vm}}, {3{va}}, i0, i1, rms};
		// reversed current angle: a swapped source select shows at once
		src1 <= {{3{im}}, {3{ia ^ 16'h8000}}, {3{vm}}, {3{va}}, i0, i1, rms};
	end
endmodule
`default_nettype wire

// ===== sim/pnoc_top_tb.sv
// self-checking bench for pnoc_top: every result is read back over the register port
// assumes a short protection pass (10 cycles) and the measurement model
`timescale 1ns/1ps
`default_nettype none
module pnoc_top_tb;
	localparam int PC = 10;
	localparam logic [15:0] DTAB [6] = '{16'h0000, 16'h4000, 16'h4001, 16'h8000, 16'hC000, 16'hBFFF};
	localparam logic [5:0] DEXP = 6'b101100;
	logic                mclk;
	logic                reset;
	logic                reg_wr;
	logic                reg_rd;
	logic                rd_q;
	logic                pib;
	logic                ntb;
	logic                nib;
	logic                pass_tick;
	logic [7:0]          reg_addr;
	logic [31:0]         reg_wdata;
	logic [31:0]         reg_rdata;
	logic [15:0]         im, ia, vm, va, i0, i1, rms, base;
	pnoc_pkg::pnoc_src_s s0, s1;
	pnoc_pkg::pnoc_out_s po;
	logic [31:0]         expq[$];
	int                  mismatches;
	int                  tests_run;

	pnoc_meas_model i_meas (.mclk(mclk), .im(im), .ia(ia), .vm(vm), .va(va), .i0(i0),
		.i1(i1), .rms(rms), .src0(s0), .src1(s1));
	pnoc_top #(.PASS_CYCLES(PC)) i_dut (.mclk(mclk), .reset(reset), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.meas_src0(s0), .meas_src1(s1), .phase_ioc_block(pib), .neutral_toc_block(ntb),
		.neutral_ioc_block(nib), .prot_out(po), .pass_tick(pass_tick));

	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD %0t read %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic final_report();
		if (mismatches == 0 && tests_run > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= w;
		reg_rd    <= !w;
		@(posedge mclk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	// expectation noted before the strobe; the monitor pops it with the data
	task automatic rd(input logic [7:0] a, input logic [15:0] m, input logic [15:0] e);
		expq.push_back({m, e & m});
		bus(1'b0, a, 32'h0);
	endtask
	task automatic passes(input int n);
		repeat (n) begin
			@(posedge mclk);
			while (pass_tick !== 1'b1) @(posedge mclk);
		end
	endtask
	// two passes: one may still see the model's previous setpoint
	task automatic pst(input logic [15:0] m, input logic [15:0] e);
		passes(2);
		rd(pnoc_pkg::REG_STATUS, m, e);
	endtask

	always @(posedge mclk) begin
		if (rd_q) begin
			check(reg_rdata[15:0] & expq[0][31:16], expq[0][15:0]);
			void'(expq.pop_front());
		end
		rd_q <= reg_rd;
	end

	initial begin
		repeat (40000) @(posedge mclk);
		mismatches++;
		final_report();
	end

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		mismatches = 0;
		tests_run = 0;
		reset = 1'b1;
		{reg_wr, reg_rd, rd_q, pib, ntb, nib, reg_addr, reg_wdata} = '0;
		{im, ia, vm, va, i0, i1, rms} = '0;
		void'($urandom(58));
		base = 16'($urandom);
		repeat (20) @(posedge mclk);
		reset <= 1'b0;
		rd(pnoc_pkg::REG_CTRL, 16'hFFFF, 16'h0000);
		rd(pnoc_pkg::REG_POL_THR, 16'hFFFF, 16'h01F4);
		rd(pnoc_pkg::REG_CT_NOM, 16'hFFFF, 16'h2710);
		rd(8'h2C, 16'hFFFF, 16'h0000);
		// direction zone edges around a random polarizing angle
		im <= 16'h1388;
		vm <= 16'h1388;
		va <= base;
		wr(pnoc_pkg::REG_CTRL, 32'h1);
		for (int k = 0; k < 6; k++) begin
			ia <= base + DTAB[k];
			pst(16'h0007, DEXP[k] ? 16'h0007 : 16'h0000);
		end
		wr(pnoc_pkg::REG_CHAR_ANG, 32'h4000);
		ia <= base + 16'h8000;
		pst(16'h0007, 16'h0000);
		ia <= base + 16'h8001;
		pst(16'h0007, 16'h0007);
		wr(pnoc_pkg::REG_CHAR_ANG, 32'h0);
		wr(pnoc_pkg::REG_CTRL, 32'h3);
		ia <= base;
		pst(16'h0007, 16'h0007);
		// current gate at the 5 % boundary, then disabled
		wr(pnoc_pkg::REG_CTRL, 32'h1);
		ia <= base + 16'h8000;
		im <= 16'h01F3;
		pst(16'h0007, 16'h0000);
		im <= 16'h01F4;
		pst(16'h0007, 16'h0007);
		wr(pnoc_pkg::REG_CTRL, 32'h5);
		pst(16'h0007, 16'h0000);
		wr(pnoc_pkg::REG_CTRL, 32'h0);
		pst(16'h0007, 16'h0000);
		// phase instantaneous with one 10 ms step
		im <= 16'h2711;
		wr(pnoc_pkg::REG_PIOC_DLY, 32'h1);
		wr(pnoc_pkg::REG_CTRL, 32'h80);
		pst(16'h01F8, 16'h0038);
		passes(10);
		rd(pnoc_pkg::REG_STATUS, 16'h01C0, 16'h01C0);
		pib <= 1'b1;
		pst(16'h01F8, 16'h0000);
		pib <= 1'b0;
		wr(pnoc_pkg::REG_CTRL, 32'hC1);
		pst(16'h003F, 16'h0007);
		ia <= base;
		pst(16'h003F, 16'h0038);
		// neutral instantaneous: 3*(4000-16000/16) = 9000
		wr(pnoc_pkg::REG_CTRL, 32'h200);
		wr(pnoc_pkg::REG_NIOC_PKP, 32'h2327);
		i0 <= 16'h0FA0;
		i1 <= 16'h3E80;
		pst(16'h1800, 16'h1800);
		wr(pnoc_pkg::REG_NIOC_PKP, 32'h2329);
		pst(16'h1800, 16'h0000);
		wr(pnoc_pkg::REG_NIOC_PKP, 32'h2327);
		nib <= 1'b1;
		pst(16'h1800, 16'h0000);
		nib <= 1'b0;
		// neutral time: 3*i0 = 12000 over 10000, target 10 passes
		i1 <= 16'h0000;
		wr(pnoc_pkg::REG_NTOC_TDM, 32'h1);
		wr(pnoc_pkg::REG_CTRL, 32'h100);
		pst(16'h0600, 16'h0200);
		passes(10);
		rd(pnoc_pkg::REG_STATUS, 16'h0600, 16'h0600);
		i0 <= 16'h0000;
		pst(16'h0600, 16'h0200);
		passes(15);
		rd(pnoc_pkg::REG_STATUS, 16'h0600, 16'h0000);
		wr(pnoc_pkg::REG_CTRL, 32'h120);
		i0 <= 16'h0FA0;
		passes(5);
		i0 <= 16'h0000;
		pst(16'h0600, 16'h0000);
		i0 <= 16'h0FA0;
		// saturate first: an accumulator the block fails to clear would operate
		passes(10);
		ntb <= 1'b1;
		passes(2);
		ntb <= 1'b0;
		pst(16'h0600, 16'h0200);
		wr(pnoc_pkg::REG_CTRL, 32'h130);
		i0 <= 16'h0000;
		rms <= 16'h2EE0;
		pst(16'h0200, 16'h0200);
		i0 <= 16'h0FA0;
		rms <= 16'h2328;
		pst(16'h0200, 16'h0000);
		// voltage memory: collapse to exactly the threshold, live angle turned
		wr(pnoc_pkg::REG_CTRL, 32'h9);
		im <= 16'h1388;
		vm <= 16'h1388;
		ia <= base;
		pst(16'hE007, 16'h0000);
		vm <= 16'h01F4;
		va <= base + 16'h8000;
		pst(16'hE007, 16'h0000);
		passes(988);
		rd(pnoc_pkg::REG_STATUS, 16'hE007, 16'h0000);
		passes(16);
		rd(pnoc_pkg::REG_STATUS, 16'hE007, 16'hE007);
		wr(pnoc_pkg::REG_CTRL, 32'h1);
		pst(16'h0007, 16'h0000);
		vm <= 16'h1388;
		va <= base;
		ia <= base + 16'h8000;
		pst(16'hE007, 16'h0007);
		repeat (3) @(posedge mclk);
		final_report();
	end
endmodule
`default_nettype wire
